// *** rtl/msu_pkg.sv ***
package msu_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned MSU_DW      = 24;   // measured value width
  localparam int unsigned MSU_EW      = 32;   // energy counter width
  localparam int unsigned MSU_CH      = 9;    // reference candidates
  localparam int unsigned MSU_AW      = 5;    // register address width

  // energy counter limit, 999 999.99 held in hundredths
  localparam logic [31:0] MSU_EMAX_FIXED = 32'h05F5_E0FF;

  // period base: one tick per millisecond
  localparam int unsigned MSU_CLK_HZ  = 20_000_000;
  localparam int unsigned MSU_TICK_US = 1000;
  localparam int unsigned MSU_TICK_CYC = (MSU_CLK_HZ / 1_000_000) * MSU_TICK_US;

  // ----------------------------------------------------------------
  // register offsets (word index)
  // ----------------------------------------------------------------
  localparam logic [4:0] MSU_R_CFG    = 5'h00;
  localparam logic [4:0] MSU_R_CMD    = 5'h01;
  localparam logic [4:0] MSU_R_CUTOFF = 5'h02;
  localparam logic [4:0] MSU_R_DUR_I  = 5'h03;
  localparam logic [4:0] MSU_R_DUR_V  = 5'h04;
  localparam logic [4:0] MSU_R_DUR_P  = 5'h05;
  localparam logic [4:0] MSU_R_EMAX   = 5'h06;
  localparam logic [4:0] MSU_R_STAT   = 5'h07;
  localparam logic [4:0] MSU_R_MASK   = 5'h08;
  localparam logic [4:0] MSU_R_REF    = 5'h09;
  localparam logic [4:0] MSU_R_DISP   = 5'h0A;
  localparam logic [4:0] MSU_R_MIN    = 5'h0B;
  localparam logic [4:0] MSU_R_MAX    = 5'h0C;
  localparam logic [4:0] MSU_R_AVG_I  = 5'h0D;
  localparam logic [4:0] MSU_R_AVG_V  = 5'h0E;
  localparam logic [4:0] MSU_R_AVG_P  = 5'h0F;
  localparam logic [4:0] MSU_R_PK_I   = 5'h10;
  localparam logic [4:0] MSU_R_PK_P   = 5'h11;
  localparam logic [4:0] MSU_R_ENERGY = 5'h12;

  // config field positions
  localparam int unsigned MSU_F_SCALE = 0;    // 2 bits
  localparam int unsigned MSU_F_PUNIT = 2;    // 2 bits
  localparam int unsigned MSU_F_EUNIT = 4;    // 2 bits
  localparam int unsigned MSU_F_VTLL  = 6;    // voltage_transformer_wiring
  localparam int unsigned MSU_F_VNONE = 7;    // no voltage measured
  localparam int unsigned MSU_F_WIN   = 8;    // 3 bits, sliding per quantity
  localparam int unsigned MSU_F_TRIG  = 11;   // 3 bits, edge_triggered_period
  localparam logic [31:0] MSU_CFG_RST = 32'h0000_0000;

  // status bits
  localparam int unsigned MSU_S_OVF   = 0;
  localparam int unsigned MSU_S_REF   = 1;
  localparam int unsigned MSU_S_PER   = 2;

  typedef enum logic [1:0] {MSU_SC_PU = 2'b00, MSU_SC_PRI = 2'b01,
                            MSU_SC_SEC = 2'b10} msu_scale_t;
  typedef enum logic [1:0] {MSU_U_AUTO = 2'b00, MSU_U_K = 2'b01,
                            MSU_U_M = 2'b10, MSU_U_G = 2'b11} msu_unit_t;
  typedef enum logic [1:0] {MSU_ST_IDLE = 2'b00, MSU_ST_RUN = 2'b01,
                            MSU_ST_DONE = 2'b11} msu_state_t;

  localparam logic [15:0] MSU_K_LIM = 16'h03E8;   // 1000 for prefix steps

endpackage : msu_pkg

// *** rtl/msu_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module msu_top
  import msu_pkg::*;
#(
  parameter int unsigned TICK_CYC = MSU_TICK_CYC
)(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [4:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  output logic                   irq_o,
  input  wire logic              sample_i,
  input  wire logic [MSU_DW-1:0] value_i,
  input  wire logic [MSU_DW-1:0] cur_i,
  input  wire logic [MSU_DW-1:0] volt_i,
  input  wire logic [MSU_DW-1:0] pwr_i,
  input  wire logic [MSU_DW-1:0] energy_inc_i,
  input  wire logic [15:0]       ratio_i,
  input  wire logic [MSU_CH-1:0] ch_ok_i,
  input  wire logic [15:0]       ch_angle_i [MSU_CH],
  output logic      [15:0]       rel_angle_o [MSU_CH],
  output logic      [1:0]        prefix_o,
  output logic      [1:0]        decimals_o,
  input  wire logic              minimum_reset_source_i,
  input  wire logic              maximum_reset_source_i,
  input  wire logic              current_avg_trigger_source_i,
  input  wire logic              current_avg_reset_source_i,
  input  wire logic              voltage_avg_trigger_source_i,
  input  wire logic              voltage_avg_reset_source_i,
  input  wire logic              power_avg_trigger_source_i,
  input  wire logic              power_avg_reset_source_i
);

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, a change counts when 2 and 3 agree
  // ----------------------------------------------------------------
  localparam int unsigned NP = 8;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_q, s2_q, s3_q;   // sync stages
  logic [NP-1:0] lvl_q;              // accepted level
  logic [NP-1:0] rise;               // one-cycle rising edge
  assign pin_raw = {power_avg_reset_source_i, power_avg_trigger_source_i,
                    voltage_avg_reset_source_i, voltage_avg_trigger_source_i,
                    current_avg_reset_source_i, current_avg_trigger_source_i,
                    maximum_reset_source_i, minimum_reset_source_i};

  // stages only shift; s1 feeds s2 and nothing else
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accepted level follows only agreed stages; held high acts once
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lvl_q <= '0;
    else
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  end
  logic [NP-1:0] lvl_d;
  assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  assign rise  = lvl_d & ~lvl_q;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] cfg_q, cutoff_q, emax_q;
  logic [31:0] dur_q [3];            // period lengths in ticks
  logic [2:0]  mask_q;
  logic [2:0]  cmd_rst;              // one-cycle demand reset commands
  logic        cfg_wr;
  assign cfg_wr  = wr_i && (addr_i == MSU_R_CFG);
  assign cmd_rst = (wr_i && addr_i == MSU_R_CMD) ? wdata_i[2:0] : 3'b000;

  // writable settings
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q    <= MSU_CFG_RST;
      cutoff_q <= '0;
      emax_q   <= MSU_EMAX_FIXED;
      mask_q   <= '0;
      dur_q[0] <= 32'h0000_0001;
      dur_q[1] <= 32'h0000_0001;
      dur_q[2] <= 32'h0000_0001;
    end
    else if (wr_i)
    begin
      case (addr_i)
        MSU_R_CFG:    cfg_q    <= wdata_i;
        MSU_R_CUTOFF: cutoff_q <= wdata_i;
        MSU_R_EMAX:   emax_q   <= wdata_i;
        MSU_R_MASK:   mask_q   <= wdata_i[2:0];
        MSU_R_DUR_I:  dur_q[0] <= wdata_i;
        MSU_R_DUR_V:  dur_q[1] <= wdata_i;
        MSU_R_DUR_P:  dur_q[2] <= wdata_i;
        default:      ;
      endcase
    end
  end

  msu_scale_t scale;
  msu_unit_t  punit, eunit;
  assign scale = msu_scale_t'(cfg_q[MSU_F_SCALE +: 2]);
  assign punit = msu_unit_t'(cfg_q[MSU_F_PUNIT +: 2]);
  assign eunit = msu_unit_t'(cfg_q[MSU_F_EUNIT +: 2]);

  // ----------------------------------------------------------------
  // display value: cutoff on the raw value, then scaling
  // ----------------------------------------------------------------
  logic [MSU_DW-1:0] disp_q;
  logic [39:0]       prim;
  assign prim = value_i * ratio_i;
  // cutoff touches only the display, never the statistics below
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      disp_q <= '0;
    else if (sample_i)
    begin
      if ({8'h00, value_i} < cutoff_q)
        disp_q <= '0;
      else
        case (scale)
          MSU_SC_PRI: disp_q <= prim[MSU_DW-1:0];
          MSU_SC_SEC: disp_q <= value_i;
          default:    disp_q <= value_i;             // per-unit passes raw
        endcase
    end
  end

  // prefix: auto follows primary ratio magnitude, fixed is forced
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prefix_o   <= 2'b00;
      decimals_o <= 2'b00;
    end
    else if (punit == MSU_U_AUTO)
    begin
      prefix_o   <= (ratio_i < MSU_K_LIM) ? 2'b00 : 2'b01;
      decimals_o <= (ratio_i < MSU_K_LIM) ? 2'b10 : 2'b11;
    end
    else
    begin
      prefix_o   <= 2'(punit - 2'b01);
      decimals_o <= 2'b10;
    end
  end

  // ----------------------------------------------------------------
  // energy counter with wrap
  // ----------------------------------------------------------------
  logic [MSU_EW-1:0] energy_q;
  logic [MSU_EW:0]   e_sum;
  logic [MSU_EW-1:0] e_lim;
  logic              e_ovf;
  assign e_lim = (eunit == MSU_U_AUTO) ? emax_q : MSU_EMAX_FIXED;
  assign e_sum = {1'b0, energy_q} + {9'h000, energy_inc_i};
  assign e_ovf = sample_i && (e_sum > {1'b0, e_lim});
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      energy_q <= '0;
    else if (e_ovf)
      energy_q <= '0;
    else if (sample_i)
      energy_q <= e_sum[MSU_EW-1:0];
  end

  // ----------------------------------------------------------------
  // reference phasor selection, priority order of candidates
  // ----------------------------------------------------------------
  // candidates 0..2 voltage, 3..5 card one current, 6..8 card two
  logic [3:0] ref_q;
  logic [3:0] ref_d;
  always_comb
  begin
    ref_d = ref_q;
    for (int k = MSU_CH - 1; k >= 0; k--)
      if (ch_ok_i[k] && !(k < 3 && cfg_q[MSU_F_VNONE]))
        ref_d = 4'(k);
    // with voltages gone the loop lands on a current
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ref_q <= '0;
    else
      ref_q <= ref_d;
  end
  // channel 0 is phase or line voltage as the wiring bit says

  // angles relative to reference; reference lands at zero
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      for (int k = 0; k < MSU_CH; k++)
        rel_angle_o[k] <= '0;
    else
      for (int k = 0; k < MSU_CH; k++)
        rel_angle_o[k] <= ch_angle_i[k] - ch_angle_i[ref_q];
  end

  // ----------------------------------------------------------------
  // min / max tracking
  // ----------------------------------------------------------------
  logic [MSU_DW-1:0] min_q, max_q;
  logic              mm_restart;
  assign mm_restart = cfg_wr;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      min_q <= '1;
    else if (mm_restart || rise[0])
      min_q <= '1;
    else if (sample_i && value_i < min_q)
      min_q <= value_i;
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      max_q <= '0;
    else if (mm_restart || rise[1])
      max_q <= '0;
    else if (sample_i && value_i > max_q)
      max_q <= value_i;
  end

  // ----------------------------------------------------------------
  // demand averaging: one lane each for current, voltage, power
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 16'h0001;
  end

  logic [MSU_DW-1:0] qin   [3];
  logic [MSU_DW-1:0] avg_q [3];
  logic [MSU_DW-1:0] pk_q  [3];
  logic [47:0]       acc_q [3];
  logic [23:0]       n_q   [3];
  logic [31:0]       per_q [3];
  wire  [2:0]        per_end;            // one bit driven by each lane
  assign qin[0] = cur_i;
  assign qin[1] = volt_i;
  assign qin[2] = pwr_i;

  // running mean as accumulator over count; sliding keeps the mean
  // as seed so the window blends instead of dropping to zero
  function automatic logic [MSU_DW-1:0] msu_div(input logic [47:0] a,
                                                input logic [23:0] n);
    logic [47:0] r;
    r = (n == '0) ? 48'h0 : a / {24'h0, n};
    return r[MSU_DW-1:0];
  endfunction : msu_div

  for (genvar g = 0; g < 3; g++) begin : g_lane
    logic clr;
    assign clr = cmd_rst[g] || rise[2*g+3];
    assign per_end[g] = cfg_q[MSU_F_TRIG+g] ? rise[2*g+2]
                      : (tick && per_q[g] + 32'h1 >= dur_q[g]);
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
        per_q[g] <= '0;
      else if (clr || per_end[g])
        per_q[g] <= '0;
      else if (tick)
        per_q[g] <= per_q[g] + 32'h1;
    end
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        acc_q[g] <= '0;
        n_q[g]   <= '0;
        avg_q[g] <= '0;
        pk_q[g]  <= '0;
      end
      else if (clr)
      begin
        acc_q[g] <= '0;
        n_q[g]   <= '0;
        avg_q[g] <= '0;
        pk_q[g]  <= '0;
      end
      else if (per_end[g])
      begin
        avg_q[g] <= msu_div(acc_q[g], n_q[g]);
        if (msu_div(acc_q[g], n_q[g]) > pk_q[g])
          pk_q[g] <= msu_div(acc_q[g], n_q[g]);
        if (cfg_q[MSU_F_WIN+g])
        begin
          acc_q[g] <= {24'h0, msu_div(acc_q[g], n_q[g])};
          n_q[g]   <= 24'h00_0001;
        end
        else
        begin
          acc_q[g] <= '0;
          n_q[g]   <= '0;
        end
      end
      else if (sample_i)
      begin
        acc_q[g] <= acc_q[g] + {24'h0, qin[g]};
        n_q[g]   <= n_q[g] + 24'h00_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: set wins over read-clear
  // ----------------------------------------------------------------
  logic [2:0] stat_q, ev;
  logic       stat_rd;
  logic [3:0] ref_prev_q;
  assign stat_rd = rd_i && (addr_i == MSU_R_STAT);
  assign ev = {|per_end, ref_prev_q != ref_q, e_ovf};
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stat_q     <= '0;
      ref_prev_q <= '0;
    end
    else
    begin
      ref_prev_q <= ref_q;
      stat_q     <= (stat_rd ? 3'b000 : stat_q) | ev;
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // read data, one cycle after the strobe, zero when idle or unmapped
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_o <= '0;
    else if (!rd_i)
      rdata_o <= '0;
    else
      case (addr_i)
        MSU_R_CFG:    rdata_o <= cfg_q;
        MSU_R_CUTOFF: rdata_o <= cutoff_q;
        MSU_R_DUR_I:  rdata_o <= dur_q[0];
        MSU_R_DUR_V:  rdata_o <= dur_q[1];
        MSU_R_DUR_P:  rdata_o <= dur_q[2];
        MSU_R_EMAX:   rdata_o <= emax_q;
        MSU_R_STAT:   rdata_o <= {29'h0, stat_q};
        MSU_R_MASK:   rdata_o <= {29'h0, mask_q};
        MSU_R_REF:    rdata_o <= {28'h0, ref_q};
        MSU_R_DISP:   rdata_o <= {8'h0, disp_q};
        MSU_R_MIN:    rdata_o <= {8'h0, min_q};
        MSU_R_MAX:    rdata_o <= {8'h0, max_q};
        MSU_R_AVG_I:  rdata_o <= {8'h0, avg_q[0]};
        MSU_R_AVG_V:  rdata_o <= {8'h0, avg_q[1]};
        MSU_R_AVG_P:  rdata_o <= {8'h0, avg_q[2]};
        MSU_R_PK_I:   rdata_o <= {8'h0, pk_q[0]};
        MSU_R_PK_P:   rdata_o <= {8'h0, pk_q[2]};
        MSU_R_ENERGY: rdata_o <= energy_q;
        default:      rdata_o <= '0;
      endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_REF_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 (rel_angle_o[$past(ref_q)] == 16'h0000))
    else $error("reference angle not zero");
  AST_WRAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    e_ovf |=> (energy_q == '0) && stat_q[MSU_S_OVF])
    else $error("energy did not wrap with flag");
  AST_MIN_CLR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rise[0] |=> (min_q == '1))
    else $error("minimum not cleared");
  AST_MAX_CLR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rise[1] |=> (max_q == '0))
    else $error("maximum not cleared");
  AST_CMD_CLR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cmd_rst[0] |=> (avg_q[0] == '0) && (pk_q[0] == '0))
    else $error("current demand not cleared");
  AST_PIN_CLR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rise[7] |=> (avg_q[2] == '0) && (pk_q[2] == '0))
    else $error("power demand not cleared");
  AST_ONE_EDGE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rise[0] |=> !rise[0])
    else $error("edge repeated");
  AST_FIX_REST: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (per_end[1] && !cfg_q[MSU_F_WIN+1] && !cmd_rst[1] && !rise[5]) |=> (n_q[1] == '0))
    else $error("fixed window did not restart");
  AST_CUTOFF: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sample_i && {8'h00, value_i} < cutoff_q) |=> (disp_q == '0))
    else $error("cutoff not applied");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (stat_q[MSU_S_OVF] && mask_q[MSU_S_OVF]) |-> irq_o)
    else $error("interrupt not raised");

endmodule : msu_top
`default_nettype wire

// *** bench/msu_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module msu_top_bench;
  import msu_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic              clk_i     = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic              sample_i  = 1'b0;
  logic [4:0]        addr_i    = 5'h00;
  logic [31:0]       wdata_i   = 32'h0000_0000;
  logic [MSU_DW-1:0] value_i   = 24'h00_0000;    // shared by all demand lanes
  logic [MSU_DW-1:0] einc      = 24'h00_0000;    // energy step per sample
  logic [15:0]       ratio_i   = 16'h0001;
  logic [MSU_CH-1:0] ok        = 9'h1FF;         // candidate health
  logic [15:0]       ang [MSU_CH] = '{default: 16'h0000};
  logic [15:0]       rel [MSU_CH];
  logic [7:0]        pins      = 8'h00;          // min, max, then trig/reset per lane
  logic [31:0]       rdata_o;
  logic [31:0]       r;                          // last read word
  logic              irq_o;
  logic [1:0]        prefix_o;
  logic [1:0]        decimals_o;
  logic [MSU_DW-1:0] c;
  int                seed = 32'hc17196f3;
  int                fail_count = 0;
  int                checks = 0;
  int                e;

  always #25 clk_i = ~clk_i;

  // tick shortened to 4 cycles so demand periods stay short
  msu_top #(.TICK_CYC(4)) msu_top_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .sample_i(sample_i),
    .value_i(value_i), .cur_i(value_i), .volt_i(value_i), .pwr_i(value_i),
    .energy_inc_i(einc), .ratio_i(ratio_i), .ch_ok_i(ok), .ch_angle_i(ang),
    .rel_angle_o(rel), .prefix_o(prefix_o), .decimals_o(decimals_o),
    .minimum_reset_source_i(pins[0]), .maximum_reset_source_i(pins[1]),
    .current_avg_trigger_source_i(pins[2]), .current_avg_reset_source_i(pins[3]),
    .voltage_avg_trigger_source_i(pins[4]), .voltage_avg_reset_source_i(pins[5]),
    .power_avg_trigger_source_i(pins[6]), .power_avg_reset_source_i(pins[7]));

  // ----------------------------------------------------------------
  // bus, sample and pin helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [4:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    r = rdata_o;
  endtask : rd

  task smp(input logic [23:0] v);
    @(posedge clk_i);
    value_i  <= v;
    sample_i <= 1'b1;
    @(posedge clk_i);
    sample_i <= 1'b0;
  endtask : smp

  // pins pass a synchroniser, so give the edge time to act
  task pin(input int b, input logic lv);
    @(posedge clk_i);
    pins[b] <= lv;
    repeat (8) @(posedge clk_i);
  endtask : pin

  // lowest healthy candidate, voltages skipped when unmeasured
  function automatic int ref_exp(input logic [8:0] m, input logic vn);
    for (int i = (vn ? 3 : 0); i < 9; i++)
      if (m[i] === 1'b1)
        return i;
    return 0;
  endfunction : ref_exp

  task tally_and_finish;
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // watchdog: whole run needs under a thousand cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(MSU_R_DUR_I); chk(r, 32'h0000_0001);
    rd(MSU_R_EMAX); chk(r, MSU_EMAX_FIXED);
    rd(5'h1F); chk(r, 32'h0000_0000);
    // prefix: automatic boundary, then every fixed unit
    @(posedge clk_i);
    ratio_i <= 16'h03E7;
    repeat (3) @(posedge clk_i);
    chk(prefix_o, 32'h0000_0000);
    chk(decimals_o, 32'h0000_0002);
    ratio_i <= 16'h03E8;
    repeat (3) @(posedge clk_i);
    chk(prefix_o, 32'h0000_0001);
    chk(decimals_o, 32'h0000_0003);
    for (int u = 1; u < 4; u++)
    begin
      wr(MSU_R_CFG, 32'(u << MSU_F_PUNIT));
      repeat (2) @(posedge clk_i);
      chk(prefix_o, 32'(u - 1));
      chk(decimals_o, 32'h0000_0002);
    end
    // every display scaling
    for (int s = 0; s < 3; s++)
    begin
      wr(MSU_R_CFG, 32'(s));
      c = (24'($random(seed)) & 24'h00_0FFF) | 24'h00_1000;
      smp(c);
      rd(MSU_R_DISP); chk(r, (s == 1) ? 32'(c) * 32'h0000_0001 * ratio_i : 32'(c));
    end
    // energy wrap with a small automatic limit; overflow raises the interrupt
    wr(MSU_R_CFG, 32'h0000_0000);
    wr(MSU_R_EMAX, 32'h0000_0064);
    wr(MSU_R_MASK, 32'h0000_0001);
    rd(MSU_R_STAT);
    einc <= 24'h00_001E;
    repeat (3) smp(24'h00_2000);
    rd(MSU_R_ENERGY); chk(r, 32'h0000_005A);
    chk(irq_o, 32'h0000_0000);
    smp(24'h00_2000);
    einc <= 24'h00_0000;
    #1;
    chk(irq_o, 32'h0000_0001);
    rd(MSU_R_STAT); chk(r[0], 32'h0000_0001);
    #1;
    chk(irq_o, 32'h0000_0000);
    rd(MSU_R_ENERGY); chk(r, 32'h0000_0000);
    // reference selection, first pass with every channel healthy
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clk_i);
      ok <= (k == 0) ? 9'h1FF : (9'($random(seed)) | 9'h100);
      for (int j = 0; j < 9; j++)
        ang[j] <= 16'($random(seed));
      wr(MSU_R_CFG, 32'((k & 3) << MSU_F_VTLL));
      repeat (3) @(posedge clk_i);
      e = ref_exp(ok, k[1]);
      rd(MSU_R_REF); chk(r, 32'(e));
      chk(rel[e], 32'h0000_0000);
      chk(rel[8], 16'(ang[8] - ang[e]));
    end
    // min/max with cutoff, separate reset edges and held pins
    wr(MSU_R_CUTOFF, 32'h0000_03E8);
    wr(MSU_R_CFG, 32'h0000_0000);
    smp(24'h00_01F4);
    rd(MSU_R_DISP); chk(r, 32'h0000_0000);
    smp(24'h00_012C);
    smp(24'h00_0384);
    rd(MSU_R_MIN); chk(r, 32'h0000_012C);
    pin(0, 1'b1);
    rd(MSU_R_MIN); chk(r[23:0], 24'hFF_FFFF);
    rd(MSU_R_MAX); chk(r, 32'h0000_0384);
    smp(24'h00_02BC);
    smp(24'h00_0320);
    rd(MSU_R_MIN); chk(r, 32'h0000_02BC);
    pin(1, 1'b1);
    smp(24'h00_0064);
    rd(MSU_R_MAX); chk(r, 32'h0000_0064);
    pin(0, 1'b0);
    pin(1, 1'b0);
    wr(MSU_R_CFG, 32'h0000_0000);
    smp(24'h00_0032);
    rd(MSU_R_MAX); chk(r, 32'h0000_0032);
    wr(MSU_R_CUTOFF, 32'h0000_0000);
    // demand per lane: fixed, command reset, sliding, pin reset, trigger
    for (int q = 0; q < 3; q++)
    begin
      wr(5'(MSU_R_DUR_I + q), 32'h0000_0002);
      wr(MSU_R_CFG, 32'h0000_0000);
      c = (24'($random(seed)) & 24'h00_FFFF) | 24'h00_0100;
      // earlier scenarios left larger means in the peaks; start clean
      wr(MSU_R_CMD, 32'(1 << q));
      repeat (12) smp(c);
      rd(5'(MSU_R_AVG_I + q)); chk(r, 32'(c));
      if (q != 1)
      begin
        rd((q == 0) ? MSU_R_PK_I : MSU_R_PK_P); chk(r, 32'(c));
      end
      // sliding set first so no empty period seeds the window after the clear
      wr(MSU_R_CFG, 32'(1 << (MSU_F_WIN + q)));
      wr(MSU_R_CMD, 32'(1 << q));
      rd(5'(MSU_R_AVG_I + q)); chk(r, 32'h0000_0000);
      repeat (12) smp(c);
      rd(5'(MSU_R_AVG_I + q)); chk(r, 32'(c));
      pin(3 + 2 * q, 1'b1);
      rd(5'(MSU_R_AVG_I + q)); chk(r, 32'h0000_0000);
      pin(3 + 2 * q, 1'b0);
      wr(MSU_R_CFG, 32'(1 << (MSU_F_TRIG + q)));
      pin(2 + 2 * q, 1'b1);
      pin(2 + 2 * q, 1'b0);
      repeat (6) smp(c + 24'h00_0001);
      pin(2 + 2 * q, 1'b1);
      rd(5'(MSU_R_AVG_I + q)); chk(r, 32'(c + 24'h00_0001));
      pin(2 + 2 * q, 1'b0);
    end
    tally_and_finish();
  end
endmodule : msu_top_bench
`default_nettype wire
